// ---- bench/tb_top.sv ----
/*
  self-checking bench for the periodic realtime counter: register table
  rows, then prescaler, source, wrap, flag, interrupt and reset cases.
  assumes prc_pkg and prc_counter are compiled first; one 200 MHz clock.
*/
`timescale 1ns/1ps

module tb_top;
  // ==========================================================
  // row of the register table: request beside the expected answer
  typedef struct packed {
    logic        wr;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] q;
    logic        e;
  } prc_tb_row_t;

  logic                  i_clk   = 1'b0;  // bench clock
  logic                  i_reset = 1'b1;  // held for five edges
  prc_pkg::prc_apb_req_t req     = '0;    // apb request lines
  logic [2:0]            src     = 3'h0;  // low power, external, internal
  logic                  o_pready;
  logic [31:0]           o_prdata;
  logic                  o_pslverr;
  logic                  o_irq;
  int                    fails       = 0;
  int                    check_count = 0;
  logic [31:0]           rdat;
  logic                  rerr;
  prc_tb_row_t           rows [0:11];

  always #2.5 i_clk = ~i_clk;

  prc_counter prc_counter_inst (
    .i_clk                 (i_clk),
    .i_reset               (i_reset),
    .i_apb                 (req),
    .i_low_power_osc_clock (src[0]),
    .i_external_ref_clock  (src[1]),
    .i_internal_ref_clock  (src[2]),
    .o_pready              (o_pready),
    .o_prdata              (o_prdata),
    .o_pslverr             (o_pslverr),
    .o_irq                 (o_irq)
  );

  // ==========================================================
  // comparisons and the closing task
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // apb master: waits one edge first so two calls never collide
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge i_clk);
    req.psel    <= 1'b1;
    req.pwrite  <= wr;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge i_clk);
    req.penable <= 1'b1;
    // the slave's latency is not assumed, only bounded
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    r = o_prdata;
    e = o_pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    if (n >= 50) begin
      fails++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdat, rerr);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rdat, rerr);
    chk32(rdat, exp);
  endtask

  // slow source edges: two cycles high, three low, well under i_clk/2
  task automatic pulse(input int s, input int cnt);
    repeat (cnt) begin
      @(posedge i_clk);
      src[s] <= 1'b1;
      repeat (2) @(posedge i_clk);
      src[s] <= 1'b0;
      repeat (2) @(posedge i_clk);
    end
  endtask

  // ==========================================================
  // watchdog: the whole run needs a few thousand cycles
  initial begin
    repeat (20000) @(posedge i_clk);
    fails++;
    test_done();
  end

  // ==========================================================
  // main sequence
  initial begin
    rows = '{
      '{1'b0, 8'h00, 32'h0, 32'h00, 1'b0},
      '{1'b0, 8'h04, 32'h0, 32'h00, 1'b0},
      '{1'b0, 8'h08, 32'h0, 32'h00, 1'b0},
      '{1'b1, 8'h08, 32'hFF, 32'h0, 1'b0},
      '{1'b0, 8'h08, 32'h0, 32'hFF, 1'b0},
      '{1'b1, 8'h04, 32'h33, 32'h0, 1'b0},
      '{1'b0, 8'h04, 32'h0, 32'h00, 1'b0},
      '{1'b0, 8'h0C, 32'h0, 32'h00, 1'b1},
      '{1'b1, 8'h0C, 32'h12, 32'h0, 1'b1},
      '{1'b1, 8'h00, 32'hFFFFFF76, 32'h0, 1'b0},
      '{1'b0, 8'h00, 32'h0, 32'h76, 1'b0},
      '{1'b1, 8'h00, 32'h0, 32'h0, 1'b0}
    };
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    chk1(o_irq, 1'b0);
    // register table: reset values, read-only count, unmapped place
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d, rdat, rerr);
      if (!rows[i].wr) begin
        chk32(rdat, rows[i].q);
      end
      chk1(rerr, rows[i].e);
    end
    // prescaler off: edges are ignored
    pulse(0, 2);
    rd(8'h04, 32'h00);
    // divide by 8 from the low power source; other sources ignored
    wr(8'h00, 32'h01);
    pulse(0, 15);
    rd(8'h04, 32'h01);
    pulse(0, 1);
    pulse(1, 8);
    rd(8'h04, 32'h02);
    wr(8'h00, 32'h02);
    rd(8'h04, 32'h00);
    pulse(0, 32);
    rd(8'h04, 32'h01);
    wr(8'h08, 32'hFF);
    rd(8'h04, 32'h00);
    pulse(0, 32);
    wr(8'h00, 32'h48);
    rd(8'h04, 32'h00);
    pulse(2, 1);
    pulse(0, 1);
    rd(8'h04, 32'h01);
    // external source with source bit 0 set: ratio of one thousand
    wr(8'h00, 32'h28);
    rd(8'h00, 32'h28);
    pulse(1, 999);
    pulse(2, 2);
    rd(8'h04, 32'h00);
    pulse(1, 1);
    rd(8'h04, 32'h01);
    // wrap at modulo 2 with the interrupt enabled
    wr(8'h08, 32'h02);
    wr(8'h00, 32'h58);
    pulse(2, 2);
    rd(8'h00, 32'h58);
    chk1(o_irq, 1'b0);
    pulse(2, 1);
    rd(8'h04, 32'h00);
    rd(8'h00, 32'hD8);
    chk1(o_irq, 1'b1);
    wr(8'h00, 32'h58);
    rd(8'h00, 32'hD8);
    wr(8'h00, 32'h48);
    rd(8'h00, 32'hC8);
    chk1(o_irq, 1'b0);
    wr(8'h00, 32'hC8);
    rd(8'h00, 32'h48);
    // modulo zero flags on every prescaler output edge
    wr(8'h08, 32'h00);
    pulse(2, 1);
    rd(8'h00, 32'hC8);
    wr(8'h00, 32'hD8);
    rd(8'h00, 32'h58);
    pulse(2, 1);
    rd(8'h00, 32'hD8);
    // the clear lands on the very edge of a wrap: the flag must stay
    fork
      wr(8'h00, 32'hD8);
      begin
        repeat (3) @(posedge i_clk);
        src[2] <= 1'b1;
        repeat (2) @(posedge i_clk);
        src[2] <= 1'b0;
        repeat (2) @(posedge i_clk);
      end
    join
    rd(8'h00, 32'hD8);
    chk1(o_irq, 1'b1);
    // second reset in mid-run with the flag and irq set
    @(posedge i_clk);
    i_reset <= 1'b1;
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    chk1(o_irq, 1'b0);
    rd(8'h00, 32'h00);
    rd(8'h08, 32'h00);
    test_done();
  end
endmodule

// ---- src/prc_counter.sv ----
/*
  periodic realtime counter: apb slave with the status/control, count and
  modulo registers, source edge detect, prescaler, 8-bit modulo counter and
  a level interrupt.
  assumes the three source clocks arrive as plain inputs synchronous to
  i_clk and much slower than it, and a single apb master.
*/
`timescale 1ns/1ps

module prc_counter (
  input  wire logic                  i_clk,
  input  wire logic                  i_reset,
  input  wire prc_pkg::prc_apb_req_t i_apb,
  input  wire logic                  i_low_power_osc_clock,
  input  wire logic                  i_external_ref_clock,
  input  wire logic                  i_internal_ref_clock,
  output logic                       o_pready,
  output logic [31:0]                o_prdata,
  output logic                       o_pslverr,
  output logic                       o_irq
);

  // ==========================================================
  // register state
  logic [1:0]                  clock_source_select;  // source choice
  logic [3:0]                  prescale_select;      // divide choice
  logic                        period_irq_enable;    // irq mask
  logic                        period_flag;          // sticky wrap event
  logic [7:0]                  modulo_value;         // compare value
  logic [7:0]                  count_value;          // live count
  logic [prc_pkg::PRC_PS_W-1:0] presc_count;         // prescaler state
  logic [2:0]                  src_prev;             // last source levels

  // ==========================================================
  // bus decode
  logic acc;         // access phase, answer given this cycle
  logic wr;          // write taking effect this edge
  logic wr_status;   // write to status_control_reg
  logic wr_modulo;   // write to modulo register
  logic hit;         // address maps to a register
  logic [7:0] wdat;  // low byte of write data

  // the answer comes one cycle into the access phase; that edge is
  // the one at which writes land
  assign acc       = i_apb.psel & i_apb.penable & o_pready;
  assign wr        = acc & i_apb.pwrite;
  assign wdat      = i_apb.pwdata[7:0];
  assign wr_status = wr & (i_apb.paddr == prc_pkg::PRC_ADDR_STATUS_CONTROL);
  assign wr_modulo = wr & (i_apb.paddr == prc_pkg::PRC_ADDR_MODULO);
  assign hit = (i_apb.paddr == prc_pkg::PRC_ADDR_STATUS_CONTROL) |
               (i_apb.paddr == prc_pkg::PRC_ADDR_COUNT) |
               (i_apb.paddr == prc_pkg::PRC_ADDR_MODULO);

  // ==========================================================
  // write side effects
  logic [1:0] wr_clks;     // source select field of written byte
  logic [3:0] wr_ps;       // prescale select field of written byte
  logic       restart;     // clear prescaler and counter this edge

  assign wr_clks = wdat[prc_pkg::PRC_CLKS_LSB +: 2];
  assign wr_ps   = wdat[prc_pkg::PRC_PS_LSB +: 4];

  // only a changed select restarts, any modulo write does; rewriting the same select keeps phase
  assign restart =
    (wr_status & (wr_clks != clock_source_select)) |
    (wr_status & (wr_ps != prescale_select)) |
    wr_modulo;

  // ==========================================================
  // source selection and edge detect
  logic [2:0] src_now;   // {internal, external, low power}
  logic       src_tick;  // rising edge of the selected source

  assign src_now = {i_internal_ref_clock, i_external_ref_clock,
                    i_low_power_osc_clock};

  // sample all three so a switch never sees a stale previous level
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      src_prev <= 3'h0;
    end else begin
      src_prev <= src_now;
    end
  end

  always_comb begin
    case (clock_source_select)
      2'h0:    src_tick = src_now[0] & ~src_prev[0];
      2'h1:    src_tick = src_now[1] & ~src_prev[1];
      default: src_tick = src_now[2] & ~src_prev[2];
    endcase
  end

  // ==========================================================
  // prescaler
  logic [prc_pkg::PRC_PS_W-1:0] divisor;     // selected ratio
  logic [prc_pkg::PRC_PS_W-1:0] div_last;    // terminal prescaler value
  logic                         presc_tick;  // one prescaler output edge
  logic                         presc_on;    // prescaler running

  assign divisor  = prc_pkg::PRC_DIV_TABLE[{clock_source_select[0],
                                            prescale_select}];
  assign div_last = divisor - 18'h00001;
  assign presc_on = (prescale_select != 4'h0);
  assign presc_tick = presc_on & src_tick & (presc_count == div_last)
                      & ~restart;

  // counts source edges, wraps at the ratio; off holds it at zero
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      presc_count <= '0;
    end else if (restart || !presc_on) begin
      presc_count <= '0;
    end else if (src_tick) begin
      if (presc_count == div_last) begin
        presc_count <= '0;
      end else begin
        presc_count <= presc_count + 18'h00001;
      end
    end
  end

  // ==========================================================
  // main counter
  logic wrap;  // counter leaves the modulo value this edge

  // with modulo zero every prescaler edge is a wrap
  assign wrap = presc_tick & (count_value == modulo_value);

  // the count register is never written by the bus
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      count_value <= prc_pkg::PRC_COUNT_RESET;
    end else if (restart) begin
      count_value <= 8'h00;
    end else if (wrap) begin
      count_value <= 8'h00;
    end else if (presc_tick) begin
      count_value <= count_value + 8'h01;
    end
  end

  // ==========================================================
  // control fields of status_control_reg
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      clock_source_select <= prc_pkg::PRC_CLKS_RESET;
      prescale_select     <= prc_pkg::PRC_PS_RESET;
      period_irq_enable   <= 1'b0;
    end else if (wr_status) begin
      clock_source_select <= wr_clks;
      prescale_select     <= wr_ps;
      period_irq_enable   <= wdat[prc_pkg::PRC_IRQEN_BIT];
    end
  end

  // modulo register, full byte range accepted
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      modulo_value <= prc_pkg::PRC_MOD_RESET;
    end else if (wr_modulo) begin
      modulo_value <= wdat;
    end
  end

  // ==========================================================
  // sticky flag; a wrap beats a clear in the same cycle
  logic flag_clr;  // write one to the flag bit

  assign flag_clr = wr_status & wdat[prc_pkg::PRC_FLAG_BIT];

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      period_flag <= 1'b0;
    end else if (wrap) begin
      period_flag <= 1'b1;
    end else if (flag_clr) begin
      period_flag <= 1'b0;
    end
  end

  // level interrupt, one cycle behind the flag
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= period_flag & period_irq_enable;
    end
  end

  // ==========================================================
  // apb answer: pready one cycle into access, data and error with it
  logic [7:0] next_rdata;  // read value of addressed register
  logic [7:0] status_rd;   // status_control_reg as read

  assign status_rd = {period_flag, clock_source_select,
                      period_irq_enable, prescale_select};

  always_comb begin
    case (i_apb.paddr)
      prc_pkg::PRC_ADDR_STATUS_CONTROL: next_rdata = status_rd;
      prc_pkg::PRC_ADDR_COUNT:          next_rdata = count_value;
      prc_pkg::PRC_ADDR_MODULO:         next_rdata = modulo_value;
      default:                          next_rdata = 8'h00;
    endcase
  end

  // unmapped addresses answer with pslverr and zero data
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h00000000;
      o_pslverr <= 1'b0;
    end else if (i_apb.psel && i_apb.penable && !o_pready) begin
      o_pready  <= 1'b1;
      o_prdata  <= {24'h000000, next_rdata};
      o_pslverr <= ~hit;
    end else begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end

  // ==========================================================
  // checker model of the prescaler: a second count of source edges
  // since the last output edge, kept apart from the prescaler so that
  // the ratio check does not lean on the prescaler's own compare
  logic [prc_pkg::PRC_PS_W-1:0] edges_seen;  // source edges this period

  always_ff @(posedge i_clk) begin
    if (i_reset || restart || !presc_on) begin
      edges_seen <= '0;
    end else if (presc_tick) begin
      edges_seen <= '0;
    end else if (src_tick) begin
      edges_seen <= edges_seen + 18'h00001;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  reset_state_a : assert property (
    $past(i_reset) |-> (count_value == 8'h00) && (modulo_value == 8'h00)
                       && (prescale_select == 4'h0) && !period_flag)
    else $error("state not cleared by reset");

  default_src_a : assert property (
    $past(i_reset) && !wr_status |=> clock_source_select == 2'h0)
    else $error("default source is not the low power oscillator");

  presc_off_a : assert property (
    (prescale_select == 4'h0) |=> $stable(count_value) || $past(restart))
    else $error("counter moved with prescaler off");

  src_change_a : assert property (
    wr_status && (wr_clks != clock_source_select)
      |=> (count_value == 8'h00) && (presc_count == '0))
    else $error("source change did not clear counters");

  ps_change_a : assert property (
    wr_status && (wr_ps != prescale_select)
      |=> (count_value == 8'h00) && (presc_count == '0))
    else $error("prescale change did not clear counters");

  div_ratio_a : assert property (
    src_tick && presc_on && !restart
      |-> presc_tick == (edges_seen == div_last))
    else $error("prescaler output not at divide ratio");

  count_step_a : assert property (
    presc_tick && (count_value != modulo_value) && !restart
      |=> count_value == $past(count_value) + 8'h01)
    else $error("counter did not advance by one");

  wrap_flag_a : assert property (
    presc_tick && (count_value == modulo_value)
      |=> (count_value == 8'h00) && period_flag)
    else $error("wrap did not clear count and set flag");

  mod_write_a : assert property (
    wr_modulo |=> (count_value == 8'h00) && (modulo_value == $past(wdat)))
    else $error("modulo write did not restart counter");

  irq_level_a : assert property (
    period_flag && period_irq_enable ##1 period_flag && period_irq_enable
      |-> o_irq)
    else $error("interrupt missing while flag enabled");

  w1c_clear_a : assert property (
    flag_clr && !wrap |=> !period_flag ##1 !o_irq)
    else $error("write one did not clear flag and irq");

  w0_keep_a : assert property (
    period_flag && wr_status && !wdat[prc_pkg::PRC_FLAG_BIT] |=> period_flag)
    else $error("write zero cleared the flag");

  set_wins_a : assert property (
    wrap && flag_clr |=> period_flag)
    else $error("flag lost when clear met a wrap");

  // invariants seen from outside the counting chain
  count_ro_a : assert property (
    wr && (i_apb.paddr == prc_pkg::PRC_ADDR_COUNT) && !presc_tick
      |=> $stable(count_value))
    else $error("bus write moved the count");

  flag_needs_wrap_a : assert property (
    !period_flag && !wrap |=> !period_flag)
    else $error("flag set without a wrap");

  flag_sticky_a : assert property (
    period_flag && !flag_clr |=> period_flag)
    else $error("flag dropped without a write of one");

  irq_masked_a : assert property (
    !period_irq_enable |=> !o_irq)
    else $error("interrupt raised while disabled");

  modulo_zero_a : assert property (
    presc_tick && (modulo_value == 8'h00) |=> period_flag)
    else $error("modulo zero missed a flag");

  src_pick_a : assert property (
    src_tick |-> ((clock_source_select == 2'h0) ? i_low_power_osc_clock :
                  (clock_source_select == 2'h1) ? i_external_ref_clock :
                  i_internal_ref_clock))
    else $error("edge taken from an unselected source");

  count_bound_a : assert property (
    count_value <= modulo_value)
    else $error("count ran past the modulo value");

  wrap_cov : cover property (presc_tick && (count_value == modulo_value)
                             && (modulo_value != 8'h00));
  irq_cov  : cover property (o_irq ##[1:20] flag_clr);
  race_cov : cover property (wrap && flag_clr);
  err_cov  : cover property (o_pready && o_pslverr);
  ext_cov  : cover property (presc_tick && (clock_source_select == 2'h1));

endmodule

// ---- src/prc_pkg.sv ----
/*
  periodic realtime counter package: register map, field layout, reset
  values, prescaler divide table and the bus request carrier.
  assumes a 32-bit apb master and a single 200 MHz clock domain.

  // How it works
  // - 8-bit counter, modulo compare, selector, prescaler
  // - reset stops, zeroes counter and modulo, prescaler off
  // - low power oscillator is the default source
  // - prescale select zero stops; nonzero starts it
  // - source select 00 low power, 01 ext, 1x int
  // - changed source select clears prescaler and counter
  // - changed prescale select clears prescaler and counter
  // - ratio from prescale select and source bit 0
  // - fixed binary and decimal divide ratio table
  // - modulo accepts any value 00 to FF
  // - count per prescaler period, wrap after match
  // - flag sets on modulo to zero transition
  // - modulo zero flags every prescaler output edge
  // - any modulo write clears prescaler and counter
  // - irq while flag set and enable set
  // - writing one to flag clears it
  // - write zero ignored, reset clears, counter read-only
*/
package prc_pkg;

  // ==========================================================
  // register map (byte addresses, one aligned word each)
  localparam logic [7:0] PRC_ADDR_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] PRC_ADDR_COUNT          = 8'h04;
  localparam logic [7:0] PRC_ADDR_MODULO         = 8'h08;

  // ==========================================================
  // status_control_reg field positions
  localparam int PRC_FLAG_BIT   = 7;  // period_flag, write one to clear
  localparam int PRC_CLKS_LSB   = 5;  // clock_source_select [6:5]
  localparam int PRC_IRQEN_BIT  = 4;  // period_irq_enable
  localparam int PRC_PS_LSB     = 0;  // prescale_select [3:0]

  // ==========================================================
  // reset values
  localparam logic [1:0] PRC_CLKS_RESET  = 2'h0;  // low power oscillator
  localparam logic [3:0] PRC_PS_RESET    = 4'h0;  // prescaler off
  localparam logic [7:0] PRC_COUNT_RESET = 8'h00;
  localparam logic [7:0] PRC_MOD_RESET   = 8'h00;

  // ==========================================================
  // prescaler width and divide table, index {clks[0], prescale_select}
  localparam int PRC_PS_W = 18;  // holds 200000
  localparam logic [PRC_PS_W-1:0] PRC_DIV_TABLE [0:31] = '{
    18'h00001, 18'h00008, 18'h00020, 18'h00040,
    18'h00080, 18'h00100, 18'h00200, 18'h00400,
    18'h00001, 18'h00002, 18'h00004, 18'h0000A,
    18'h00010, 18'h00064, 18'h001F4, 18'h003E8,
    18'h00001, 18'h00400, 18'h00800, 18'h01000,
    18'h02000, 18'h04000, 18'h08000, 18'h10000,
    18'h003E8, 18'h007D0, 18'h01388, 18'h02710,
    18'h04E20, 18'h0C350, 18'h186A0, 18'h30D40
  };

  // ==========================================================
  // apb request carrier, signal names as published
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } prc_apb_req_t;

endpackage
